// >>> hw/cpb_pkg.sv
// shared constants, types and helpers for the coprocessor bus ends
package cpb_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned WORDS_W = 4;
    localparam int unsigned ADDR_W  = 3;
    // ------------------------------------------------------------
    // bus cycle timing in internal clock periods
    // ------------------------------------------------------------
    localparam logic [1:0] WR_CLOCKS = 2'h2;
    localparam logic [1:0] RD_CLOCKS = 2'h3;
    // ------------------------------------------------------------
    // reset timing in core clock periods
    // ------------------------------------------------------------
    localparam logic [5:0] RESET_HOLD_CORE = 6'h28;
    localparam logic [5:0] INIT_WAIT_CORE  = 6'h32;
    // ------------------------------------------------------------
    // host register map and fields
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL   = 3'h0;
    localparam logic [ADDR_W-1:0] REG_CMD    = 3'h1;
    localparam logic [ADDR_W-1:0] REG_WDATA  = 3'h2;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] REG_RDATA  = 3'h4;
    localparam int unsigned CTRL_RESET_BIT  = 0;
    localparam int unsigned CTRL_ENABLE_BIT = 1;
    localparam int unsigned CTRL_STRAP_BIT  = 2;
    localparam int unsigned CMD_CMDN_BIT    = 0;
    localparam int unsigned CMD_WNR_BIT     = 1;
    localparam logic [1:0] CTRL_RESET_VAL   = 2'h3;
    // ------------------------------------------------------------
    // cycle kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_CTRL_RD,
        KIND_OPC_WR,
        KIND_DATA_RD,
        KIND_DATA_WR
    } cpb_kind_t;

    function automatic cpb_kind_t cpb_decode(input logic cmd_n, input logic wnr);
        return cpb_kind_t'({cmd_n, wnr});
    endfunction

    function automatic logic [1:0] cpb_clocks(input cpb_kind_t k);
        return (k == KIND_CTRL_RD || k == KIND_DATA_RD) ? RD_CLOCKS : WR_CLOCKS;
    endfunction
endpackage

// >>> hw/cpb_bus_if.sv
// pin-level carrier between host end and coprocessor end
interface cpb_bus_if;
    logic              chip_output_enable;
    logic              select_io_cycle_n;
    logic              select_high_address;
    logic              command_vs_data_n;
    logic              write_not_read;
    logic              address_strobe_n;
    logic              system_reset_in;
    logic              clocking_mode_strap;
    logic              core_clock2;
    logic [31:0]       host_data;
    logic              host_data_oe_n;
    logic [31:0]       dev_data;
    logic              dev_data_oe_n;
    logic              dev_out_oe_n;
    logic              dev_done_n;
    logic              dev_busy_n;
    logic              dev_req;
    logic              dev_error_n;
    logic [31:0]       data;
    logic              ready_n;
    logic              busy_n;
    logic              operand_transfer_request;
    logic              error_n;
    // ------------------------------------------------------------
    // wire resolution with pull levels when floating
    // ------------------------------------------------------------
    assign data = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : 32'h0);
    assign ready_n = dev_out_oe_n ? 1'b1 : dev_done_n;
    assign busy_n = dev_out_oe_n ? 1'b1 : dev_busy_n;
    assign operand_transfer_request = dev_out_oe_n ? 1'b0 : dev_req;
    assign error_n = dev_out_oe_n ? 1'b1 : dev_error_n;

    modport dev (
        input  chip_output_enable, select_io_cycle_n, select_high_address, command_vs_data_n,
        input  write_not_read, address_strobe_n, system_reset_in, clocking_mode_strap,
        input  core_clock2, data, ready_n,
        output dev_data, dev_data_oe_n, dev_out_oe_n, dev_done_n, dev_busy_n, dev_req, dev_error_n
    );
    modport host (
        output chip_output_enable, select_io_cycle_n, select_high_address, command_vs_data_n,
        output write_not_read, address_strobe_n, system_reset_in, clocking_mode_strap,
        output core_clock2, host_data, host_data_oe_n,
        input  data, ready_n, busy_n, operand_transfer_request, error_n
    );
endinterface

// >>> hw/cpb_device.sv
// coprocessor end: bus tracking, auto ready, handshake outputs
//
// Notes on behaviour
// [RQ1] other outputs float unless output enable active
// [RQ2] data driven only in selected read cycles
// [RQ3] bus logic on host clock, divided by two
// [RQ4] strap high: core timing from host clock
// [RQ5] strap low: core timing from core clock
// [RQ6] reset rising: abandon activity, go dormant
// [RQ7] host holds reset for 40 core periods
// [RQ8] reset release aligns divided clock phase
// [RQ9] host waits 50 core periods before instructions
// [RQ10] in reset: ready/busy high, request/error low
// [RQ11] request while operand words remain to move
// [RQ12] request drops before busy goes inactive
// [RQ13] busy low while executing an instruction
// [RQ14] error output copies error summary bit
// [RQ15] only no-wait clearing instructions clear error
// [RQ16] high line is one, bit 0 least significant
// [RQ17] direction ignored unless all selects active
// [RQ18] strobe and ready track cycle start
// [RQ19] cycle ends only on ready, any waits
// [RQ20] auto ready: writes two, reads three clocks
// [RQ21] host changes enable with the selects
// [RQ22] selected only when all selects in first period
// [RQ23] command line picks opcode/control versus data
// [RQ24] decode command and direction into four kinds
module cpb_device (
    input  wire logic                          i_clock,
    input  wire logic                          i_rst_n,
    cpb_bus_if.dev                             bus,
    input  wire logic                          i_load_words,
    input  wire logic [cpb_pkg::WORDS_W-1:0]   i_words,
    input  wire logic                          i_clear_error,
    input  wire logic                          i_exception,
    input  wire logic                          i_exec_done,
    input  wire logic [cpb_pkg::DATA_W-1:0]    i_rdata,
    input  wire logic [cpb_pkg::DATA_W-1:0]    i_status,
    output logic      [cpb_pkg::DATA_W-1:0]    o_word,
    output logic                               o_opcode_stb,
    output logic                               o_data_stb,
    output logic                               o_read_stb,
    output logic                               o_core_tick,
    output logic                               o_sync_mode
);
    import cpb_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic {
        D_IDLE,
        D_CYCLE
    } cpb_dstate_t;

    typedef struct packed {
        cpb_dstate_t        st;
        logic               ph;
        logic [1:0]         cnt;
        cpb_kind_t          kind;
        logic               strap;
        logic               core_q;
        logic               tick;
        logic               es;
        logic [WORDS_W-1:0] words;
        logic               req;
        logic               busy_n;
        logic               err_n;
        logic               done_n;
        logic               out_oe_n;
        logic [DATA_W-1:0]  dout;
        logic               dout_oe_n;
        logic [DATA_W-1:0]  word;
        logic               opc_stb;
        logic               data_stb;
        logic               rd_stb;
    } cpb_dev_t;

    cpb_dev_t s;
    cpb_dev_t next_s;
    logic     sel;
    logic     tick;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.opc_stb = 1'b0;
        next_s.data_stb = 1'b0;
        next_s.rd_stb = 1'b0;
        next_s.ph = ~s.ph; // RQ3
        next_s.core_q = bus.core_clock2;
        tick = s.strap ? s.ph : (bus.core_clock2 & ~s.core_q); // RQ4 RQ5
        next_s.tick = tick;
        next_s.out_oe_n = ~bus.chip_output_enable; // RQ1
        sel = bus.chip_output_enable & ~bus.select_io_cycle_n & bus.select_high_address; // RQ22
        case (s.st)
            D_IDLE: begin
                if (s.ph && !bus.address_strobe_n && sel) begin // RQ18 RQ17
                    next_s.st = D_CYCLE;
                    next_s.kind = cpb_decode(bus.command_vs_data_n, bus.write_not_read); // RQ24
                    next_s.cnt = 2'h1;
                    if (!bus.write_not_read) begin // RQ2 RQ23
                        next_s.dout = bus.command_vs_data_n ? i_rdata : i_status;
                        next_s.dout_oe_n = 1'b0;
                    end
                    if (cpb_clocks(next_s.kind) == 2'h2) begin // RQ20
                        next_s.done_n = 1'b0;
                    end
                end
            end
            D_CYCLE: begin
                if (s.ph && !bus.ready_n) begin // RQ19
                    next_s.st = D_IDLE;
                    next_s.done_n = 1'b1;
                    next_s.dout_oe_n = 1'b1;
                    case (s.kind)
                        KIND_OPC_WR: begin
                            next_s.word = bus.data; // RQ16
                            next_s.opc_stb = 1'b1;
                            next_s.busy_n = 1'b0; // RQ13
                        end
                        KIND_DATA_WR: begin
                            next_s.word = bus.data;
                            next_s.data_stb = 1'b1;
                            if (s.words != '0) next_s.words = s.words - 4'h1; // RQ11
                        end
                        KIND_DATA_RD: begin
                            next_s.rd_stb = 1'b1;
                            if (s.words != '0) next_s.words = s.words - 4'h1; // RQ11
                        end
                        default: ;
                    endcase
                end else if (s.ph) begin
                    if (s.cnt != 2'h3) next_s.cnt = s.cnt + 2'h1;
                    if (next_s.cnt == cpb_clocks(s.kind) - 2'h1) next_s.done_n = 1'b0; // RQ20
                end
            end
            default: next_s.st = D_IDLE;
        endcase
        if (!bus.chip_output_enable) next_s.dout_oe_n = 1'b1; // RQ2
        if (i_load_words) next_s.words = i_words;
        next_s.req = (next_s.words != '0); // RQ11
        if (i_exec_done && !s.req && next_s.words == '0 && s.st == D_IDLE) next_s.busy_n = 1'b1; // RQ12
        if (i_clear_error && !s.busy_n) next_s.es = 1'b0; // RQ15
        if (i_exception) next_s.es = 1'b1;
        if (tick) next_s.err_n = ~s.es; // RQ14
        if (!i_rst_n || bus.system_reset_in) begin // RQ6 RQ8
            next_s = '0;
            next_s.strap = bus.clocking_mode_strap;
            next_s.core_q = bus.core_clock2;
            next_s.out_oe_n = ~bus.chip_output_enable;
            next_s.es = 1'b1; // RQ14
            next_s.busy_n = 1'b1; // RQ10
            next_s.err_n = 1'b0;
            next_s.done_n = 1'b1;
            next_s.dout_oe_n = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        s <= next_s;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.dev_data = s.dout;
    assign bus.dev_data_oe_n = s.dout_oe_n;
    assign bus.dev_out_oe_n = s.out_oe_n;
    assign bus.dev_done_n = s.done_n;
    assign bus.dev_busy_n = s.busy_n;
    assign bus.dev_req = s.req;
    assign bus.dev_error_n = s.err_n;
    assign o_word = s.word;
    assign o_opcode_stb = s.opc_stb;
    assign o_data_stb = s.data_stb;
    assign o_read_stb = s.rd_stb;
    assign o_core_tick = s.tick;
    assign o_sync_mode = s.strap;
endmodule

// >>> hw/cpb_host.sv
// host end: register port, reset sequencing, bus cycle generation
//
// Implementation choices: the strobed register port and the register addresses.
module cpb_host (
    input  wire logic                         i_clock,
    input  wire logic                         i_rst_n,
    cpb_bus_if.host                           bus,
    input  wire logic                         i_core_clock2,
    input  wire logic [cpb_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [cpb_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                         i_write,
    input  wire logic                         i_read,
    output logic      [cpb_pkg::DATA_W-1:0]   o_rdata
);
    import cpb_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        H_RESET_HOLD,
        H_INIT_WAIT,
        H_IDLE,
        H_T1,
        H_WAIT
    } cpb_hstate_t;

    typedef struct packed {
        cpb_hstate_t       st;
        logic              ph;
        logic [5:0]        cnt;
        logic              core_out;
        logic              core_q;
        logic [1:0]        ctrl;
        logic              pend;
        logic [1:0]        pcmd;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] rd_q;
        logic              oe_en;
        logic              sel_io_n;
        logic              sel_hi;
        logic              cmd_n;
        logic              wnr;
        logic              ads_n;
        logic              sys_reset;
        logic              data_oe_n;
    } cpb_host_t;

    cpb_host_t         s;
    cpb_host_t         next_s;
    logic              core_rise;
    logic [DATA_W-1:0] rmux;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.ph = ~s.ph;
        next_s.core_out = i_core_clock2; // RQ5
        next_s.core_q = s.core_out;
        core_rise = s.core_out & ~s.core_q;
        rmux = '0;
        case (i_addr)
            REG_CTRL:   rmux = {29'h0, s.ctrl, 1'b0};
            REG_WDATA:  rmux = s.wdata;
            REG_STATUS: rmux = {25'h0, s.oe_en, s.sys_reset, (s.st == H_IDLE && !s.pend),
                                s.pend, bus.error_n, bus.operand_transfer_request, bus.busy_n};
            REG_RDATA:  rmux = s.rdata;
            default:    rmux = '0;
        endcase
        if (i_read) next_s.rd_q = rmux;
        if (i_write && i_addr == REG_WDATA) next_s.wdata = i_wdata;
        if (i_write && i_addr == REG_CMD && s.st == H_IDLE && !s.pend) begin
            next_s.pend = 1'b1;
            next_s.pcmd = {i_wdata[CMD_WNR_BIT], i_wdata[CMD_CMDN_BIT]};
        end
        case (s.st)
            H_RESET_HOLD: begin
                next_s.sys_reset = 1'b1;
                if (core_rise && s.cnt != 6'h3F) next_s.cnt = s.cnt + 6'h1;
                if (s.cnt > RESET_HOLD_CORE && s.ph) begin // RQ7 RQ8
                    next_s.sys_reset = 1'b0;
                    next_s.cnt = '0;
                    next_s.st = H_INIT_WAIT;
                end
            end
            H_INIT_WAIT: begin
                if (core_rise && s.cnt != 6'h3F) next_s.cnt = s.cnt + 6'h1;
                if (s.cnt > INIT_WAIT_CORE) next_s.st = H_IDLE; // RQ9
            end
            H_IDLE: begin
                if (s.ph) begin
                    next_s.oe_en = s.ctrl[0]; // RQ21
                    if (s.pend) begin
                        next_s.ads_n = 1'b0; // RQ22
                        next_s.sel_io_n = 1'b0;
                        next_s.sel_hi = 1'b1;
                        next_s.wnr = s.pcmd[1];
                        next_s.cmd_n = s.pcmd[0]; // RQ23
                        next_s.data_oe_n = ~s.pcmd[1];
                        next_s.st = H_T1;
                    end
                end
            end
            H_T1: begin
                if (s.ph) begin
                    next_s.ads_n = 1'b1;
                    next_s.st = H_WAIT;
                end
            end
            H_WAIT: begin
                if (s.ph && !bus.ready_n) begin // RQ19
                    if (!s.wnr) next_s.rdata = bus.data;
                    next_s.sel_io_n = 1'b1;
                    next_s.sel_hi = 1'b0;
                    next_s.data_oe_n = 1'b1;
                    next_s.pend = 1'b0;
                    next_s.st = H_IDLE;
                end
            end
            default: next_s.st = H_IDLE;
        endcase
        if (i_write && i_addr == REG_CTRL) begin
            next_s.ctrl = {i_wdata[CTRL_STRAP_BIT], i_wdata[CTRL_ENABLE_BIT]};
            if (i_wdata[CTRL_RESET_BIT]) begin
                next_s.st = H_RESET_HOLD;
                next_s.cnt = '0;
                next_s.sys_reset = 1'b1;
                next_s.pend = 1'b0;
                next_s.ads_n = 1'b1;
                next_s.sel_io_n = 1'b1;
                next_s.sel_hi = 1'b0;
                next_s.data_oe_n = 1'b1;
                next_s.oe_en = i_wdata[CTRL_ENABLE_BIT];
            end
        end
        if (!i_rst_n) begin
            next_s = '0;
            next_s.st = H_RESET_HOLD;
            next_s.ctrl = CTRL_RESET_VAL;
            next_s.oe_en = 1'b1;
            next_s.sel_io_n = 1'b1;
            next_s.ads_n = 1'b1;
            next_s.sys_reset = 1'b1;
            next_s.data_oe_n = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        s <= next_s;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.chip_output_enable = s.oe_en;
    assign bus.select_io_cycle_n = s.sel_io_n;
    assign bus.select_high_address = s.sel_hi;
    assign bus.command_vs_data_n = s.cmd_n;
    assign bus.write_not_read = s.wnr;
    assign bus.address_strobe_n = s.ads_n;
    assign bus.system_reset_in = s.sys_reset;
    assign bus.clocking_mode_strap = s.ctrl[1];
    assign bus.core_clock2 = s.core_out;
    assign bus.host_data = s.wdata;
    assign bus.host_data_oe_n = s.data_oe_n;
    assign o_rdata = s.rd_q;
endmodule

// >>> dv/cpb_checker.sv
// concurrent checks on the carrier between host end and device end
module cpb_checker (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic chip_output_enable,
    input wire logic select_io_cycle_n,
    input wire logic select_high_address,
    input wire logic command_vs_data_n,
    input wire logic write_not_read,
    input wire logic address_strobe_n,
    input wire logic system_reset_in,
    input wire logic dev_data_oe_n,
    input wire logic dev_out_oe_n,
    input wire logic dev_done_n,
    input wire logic dev_busy_n,
    input wire logic dev_req,
    input wire logic dev_error_n
);
    timeunit 1ns;
    timeprecision 1ns;
    wire sel = chip_output_enable && !select_io_cycle_n && select_high_address;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    out_float_a: assert property (!chip_output_enable [*2] |-> dev_out_oe_n)
        else $error("outputs enabled while chip disabled");
    data_drive_a: assert property (!dev_data_oe_n |-> sel && !write_not_read)
        else $error("data driven outside a selected read");
    reset_pins_a: assert property (system_reset_in [*2] |->
        dev_done_n && dev_busy_n && !dev_req && !dev_error_n && dev_data_oe_n)
        else $error("wrong output levels in reset");
    req_first_a: assert property ($rose(dev_busy_n) && !system_reset_in |-> !$past(dev_req))
        else $error("busy released while request high");
    wr_done_a: assert property ($fell(address_strobe_n) && sel && write_not_read |->
        dev_done_n [*2] ##1 !dev_done_n)
        else $error("write cycle done at wrong time");
    rd_done_a: assert property ($fell(address_strobe_n) && sel && !write_not_read |->
        dev_done_n [*4] ##1 !dev_done_n)
        else $error("read cycle done at wrong time");
    done_width_a: assert property ($fell(dev_done_n) |=> !dev_done_n ##1 dev_done_n)
        else $error("done not one period long");
    done_sel_a: assert property ($fell(dev_done_n) |-> $past(sel))
        else $error("done in an unselected cycle");
    opc_busy_a: assert property ($rose(dev_done_n) && !system_reset_in && $past(write_not_read)
        && !$past(command_vs_data_n) |-> !dev_busy_n)
        else $error("busy not set by opcode write");
    wr_cov_c: cover property ($fell(dev_done_n) && write_not_read);
    rd_cov_c: cover property ($fell(dev_done_n) && !write_not_read);
    busy_cov_c: cover property ($rose(dev_busy_n));
    err_cov_c: cover property ($rose(dev_error_n));
endmodule

// >>> dv/cpb_test.sv
// self-checking bench: host end and device end joined over the carrier
module cpb_test;
    timeunit 1ns;
    timeprecision 1ns;
    import cpb_pkg::*;
    typedef struct packed {logic cmd_n; logic wnr; logic [31:0] d; logic [2:0] stb; logic req;} cpb_row_t;
    logic              i_clock, i_rst_n, wr, rd, load, clr, exc, done, sync, tick, drove, op_stb, dat_stb, rd_stb;
    logic [1:0]        cnt = 2'h0;
    logic [2:0]        stb;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata, rdata, rd_reg, status_in, word, s;
    logic [3:0]        words;
    int                fails, checked;
    cpb_row_t          rows [4] = '{'{1'b0, 1'b1, 32'hA5C3_0F01, 3'h1, 1'b1},
                                    '{1'b1, 1'b1, 32'h8000_0001, 3'h2, 1'b1},
                                    '{1'b1, 1'b0, 32'h0123_89AB, 3'h4, 1'b0},
                                    '{1'b0, 1'b0, 32'hFEDC_7654, 3'h0, 1'b0}};
    cpb_bus_if bus ();
    cpb_host cpb_host_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(bus), .i_core_clock2(cnt[1]),
        .i_addr(addr), .i_wdata(wdata), .i_write(wr), .i_read(rd), .o_rdata(rdata));
    cpb_device cpb_device_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(bus), .i_load_words(load),
        .i_words(words), .i_clear_error(clr), .i_exception(exc), .i_exec_done(done), .i_rdata(rd_reg),
        .i_status(status_in), .o_word(word), .o_opcode_stb(op_stb), .o_data_stb(dat_stb),
        .o_read_stb(rd_stb), .o_core_tick(tick), .o_sync_mode(sync));
    cpb_checker cpb_checker_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .chip_output_enable(bus.chip_output_enable), .select_io_cycle_n(bus.select_io_cycle_n),
        .select_high_address(bus.select_high_address), .command_vs_data_n(bus.command_vs_data_n),
        .write_not_read(bus.write_not_read), .address_strobe_n(bus.address_strobe_n),
        .system_reset_in(bus.system_reset_in), .dev_data_oe_n(bus.dev_data_oe_n),
        .dev_out_oe_n(bus.dev_out_oe_n), .dev_done_n(bus.dev_done_n), .dev_busy_n(bus.dev_busy_n),
        .dev_req(bus.dev_req), .dev_error_n(bus.dev_error_n));
    // ------------------------------------------------------------
    // clocks and helpers
    // ------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    always @(posedge i_clock) cnt <= cnt + 2'h1;
    task automatic check(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge i_clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_stat(input int b, input logic v);
        logic [31:0] q;
        for (int n = 0; n < 300; n++) begin
            reg_rd(REG_STATUS, q);
            if (q[b] === v) return;
        end
        check("status wait", q, {31'h0, v} << b);
        finish_test();
    endtask
    function automatic logic pin(input int k);
        return k == 0 ? bus.error_n : (k == 1 ? bus.busy_n : bus.operand_transfer_request);
    endfunction
    task automatic wait_pin(input int k, input logic v);
        for (int n = 0; n < 40 && pin(k) !== v; n++) @(posedge i_clock) #1;
        check("handshake pin", {31'h0, pin(k)}, {31'h0, v});
        if (pin(k) !== v) finish_test();
    endtask
    task automatic pulse(input int k);
        @(posedge i_clock);
        {done, exc, clr, load} <= 4'h1 << k;
        @(posedge i_clock);
        {load, clr, exc, done} <= 4'h0;
    endtask
    task automatic cycle(input logic cmd_n, input logic wnr, input logic [31:0] d);
        {stb, drove} = 4'h0;
        reg_wr(REG_WDATA, d);
        reg_wr(REG_CMD, {30'h0, wnr, cmd_n});
        for (int n = 0; n < 40 && stb == 3'h0; n++) begin
            @(posedge i_clock);
            #1;
            stb = {rd_stb, dat_stb, op_stb};
            drove |= !bus.dev_data_oe_n;
        end
    endtask
    task automatic ticks(input int exp);
        int n = 0;
        repeat (40) begin
            @(posedge i_clock);
            #1;
            if (tick === 1'b1) n++;
        end
        check("core ticks", n, exp);
    endtask
    initial begin
        repeat (20000) @(posedge i_clock);
        check("watchdog", 32'h1, 32'h0);
        finish_test();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {i_rst_n, wr, rd, load, clr, exc, done, addr, words, wdata, rd_reg, status_in} = 110'h0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        check("reset pins", {27'h0, bus.ready_n, bus.busy_n, bus.operand_transfer_request, bus.error_n,
            bus.dev_data_oe_n}, 32'h19);
        reg_rd(REG_STATUS, s);
        check("reset status", {30'h0, s[5:4]}, 32'h2);
        reg_rd(REG_CTRL, s);
        check("ctrl", s, 32'h6);
        cycle(1'b0, 1'b1, 32'h1);
        check("early command", {29'h0, stb}, 32'h0);
        wait_stat(4, 1'b1);
        check("presence", {31'h0, bus.error_n}, 32'h0);
        @(posedge i_clock);
        words <= 4'h2;
        pulse(0);
        wait_pin(2, 1'b1);
        for (int r = 0; r < 4; r++) begin
            @(posedge i_clock);
            rd_reg <= rows[r].d;
            status_in <= ~rows[r].d;
            cycle(rows[r].cmd_n, rows[r].wnr, rows[r].d);
            check("strobe", {29'h0, stb}, {29'h0, rows[r].stb});
            check("data drive", {31'h0, drove}, {31'h0, !rows[r].wnr});
            check("busy", {31'h0, bus.busy_n}, 32'h0);
            if (rows[r].wnr) check("word", word, rows[r].d);
            if (!rows[r].wnr) reg_rd(REG_RDATA, s);
            if (!rows[r].wnr) check("read data", s, rows[r].cmd_n ? rows[r].d : ~rows[r].d);
            wait_pin(2, rows[r].req);
        end
        pulse(1);
        wait_pin(0, 1'b1);
        pulse(2);
        wait_pin(0, 1'b0);
        pulse(3);
        wait_pin(1, 1'b1);
        pulse(1);
        repeat (40) @(posedge i_clock);
        check("error held", {31'h0, bus.error_n}, 32'h0);
        check("sync mode", {31'h0, sync}, 32'h1);
        ticks(20);
        reg_wr(REG_CTRL, 32'h4);
        wait_pin(0, 1'b1);
        cycle(1'b0, 1'b1, 32'h5A);
        check("unselected", {28'h0, drove, stb}, 32'h0);
        reg_wr(REG_CTRL, 32'h3);
        wait_stat(4, 1'b1);
        reg_rd(REG_STATUS, s);
        check("abandoned", {31'h0, s[3]}, 32'h0);
        check("presence again", {31'h0, bus.error_n}, 32'h0);
        check("async mode", {31'h0, sync}, 32'h0);
        ticks(10);
        cycle(1'b0, 1'b1, 32'h0F0F_1234);
        check("async opcode", {29'h0, stb}, 32'h1);
        check("async word", word, 32'h0F0F_1234);
        finish_test();
    end
endmodule
